//--- design/hrlp_pkg.sv
//--------------------------------------------------------------
// Behaviour
// R1 - three reset sources: power-on, external low pin, upstream bus reset
// R2 - power-on timer holds internal reset for a fixed interval
// R3 - pin asserted only with good supplies; device stays in standby meanwhile
// R4 - external reset disables the phy and floats the differential pairs
// R5 - external reset aborts every transaction and keeps no state
// R6 - external reset returns every internal register to default
// R7 - external reset stops the crystal oscillator and the pll
// R8 - upstream bus reset clears the device address to zero
// R9 - upstream bus reset returns configuration to unconfigured
// R10 - bus reset while suspended returns the device to active
// R11 - upstream bus reset is never forwarded downstream
// R12 - link has three power states: l0 on, l1 sleep, l2 suspend
// R13 - l2 entry about 3 ms, exit about 2 ms from resume start
// R14 - l1 entry under 10 us, exit under 50 us
// R15 - internal reset held while power-on or pin reset active and until timer expiry
//--------------------------------------------------------------
package hrlp_pkg;
	localparam int          CLK_MHZ       = 125;
	localparam int          POR_TIME_US   = 10;
	localparam int          POR_CYCLES    = POR_TIME_US * CLK_MHZ;
	localparam int          L2_ENTRY_MS   = 3;
	localparam int          L2_EXIT_MS    = 2;
	localparam int          L2_ENTRY_CYC  = L2_ENTRY_MS * 1000 * CLK_MHZ;
	localparam int          L2_EXIT_CYC   = L2_EXIT_MS * 1000 * CLK_MHZ;
	localparam int          L1_ENTRY_US   = 10;
	localparam int          L1_EXIT_US    = 50;
	// strictly under the limit: the count plus the hand-over edge into
	// the new state lands one cycle short of the figure
	localparam int          L1_ENTRY_CYC  = L1_ENTRY_US * CLK_MHZ - 2;
	localparam int          L1_EXIT_CYC   = L1_EXIT_US * CLK_MHZ - 2;
	localparam int          CNT_W         = 20;
	localparam logic [6:0]  ADDR_RESET    = 7'h00;
	localparam logic [7:0]  CONFIG_RESET  = 8'h00;

	typedef enum logic [2:0] {
		HRLP_L0,
		HRLP_L1_ENTER,
		HRLP_L1,
		HRLP_L1_EXIT,
		HRLP_L2_ENTER,
		HRLP_L2,
		HRLP_L2_EXIT
	} hrlp_link_type;
endpackage

//--- design/hrlp_reset_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module hrlp_reset_ctrl
	import hrlp_pkg::*;
#(
	parameter int POR_CYC = POR_CYCLES
) (
	input  wire logic mclk,        // core clock
	input  wire logic rst,         // power-on detect, sync high
	input  wire logic ext_rst_n,   // external reset pin, low active
	output logic      int_rst,     // combined internal reset
	output logic      standby      // external reset standby
);
	logic [CNT_W-1:0] por_cnt;
	logic [CNT_W-1:0] next_por_cnt;
	logic             next_int_rst;
	logic             next_standby;

	always_comb begin
		next_por_cnt = por_cnt;
		if (rst || !ext_rst_n) begin // [R2]
			next_por_cnt = CNT_W'(POR_CYC);
		end else if (por_cnt != '0) begin
			next_por_cnt = por_cnt - CNT_W'(1);
		end
		// released only when power-on and pin reset are gone and timer ran out
		next_int_rst = rst || !ext_rst_n || (next_por_cnt != '0); // [R15] [R1]
		next_standby = !ext_rst_n; // [R3]
	end

	always_ff @(posedge mclk) begin
		por_cnt <= next_por_cnt;
		int_rst <= next_int_rst;
		standby <= next_standby;
	end

	property p_hold_after_release;
		@(posedge mclk) $rose(ext_rst_n) && !rst |-> ##1 int_rst;
	endproperty
	a_hold_after_release: assert property (p_hold_after_release) // [R15]
		else $error("internal reset released too early");

	property p_src_reset;
		@(posedge mclk) (rst || !ext_rst_n) |=> int_rst;
	endproperty
	a_src_reset: assert property (p_src_reset) // [R2]
		else $error("internal reset not asserted by source");
endmodule
`default_nettype wire

//--- design/hrlp_top.sv
`timescale 1ns/1ns
`default_nettype none
module hrlp_top
	import hrlp_pkg::*;
#(
	parameter int POR_CYC      = POR_CYCLES,
	parameter int L2_ENTER_CYC = L2_ENTRY_CYC,
	parameter int L2_LEAVE_CYC = L2_EXIT_CYC,
	parameter int L1_ENTER_CYC = L1_ENTRY_CYC,
	parameter int L1_LEAVE_CYC = L1_EXIT_CYC
) (
	input  wire logic       mclk,          // core clock
	input  wire logic       rst,           // power-on detect
	input  wire logic       ext_rst_n,     // external reset pin
	input  wire logic       bus_reset,     // upstream bus reset level
	input  wire logic       set_addr,      // address assign strobe
	input  wire logic [6:0] addr_in,       // address value
	input  wire logic       set_config,    // configuration strobe
	input  wire logic [7:0] config_in,     // configuration value
	input  wire logic       l1_req,        // sleep request
	input  wire logic       l2_req,        // suspend request
	input  wire logic       resume,        // resume signalling start
	input  wire logic       xact_req,      // transaction start
	output logic            int_rst,       // internal reset
	output logic            standby,       // low current standby
	output logic            phy_en,        // phy enable
	output logic            pair_oe,       // pair drive enable
	output logic            osc_en,        // crystal oscillator run
	output logic            pll_en,        // pll run
	output logic [6:0]      dev_addr,      // device address
	output logic [7:0]      dev_config,    // configuration, 0 unconfigured
	output logic            xact_busy,     // transaction in progress
	output logic [1:0]      link_state,    // 0 l0, 1 l1, 2 l2
	output logic            link_busy,     // transition ongoing
	output logic            ds_reset       // downstream reset, never set
);
	logic int_rst_w;
	logic standby_w;

	hrlp_reset_ctrl #(
		.POR_CYC (POR_CYC)
	) u_rst (
		.mclk      (mclk),
		.rst       (rst),
		.ext_rst_n (ext_rst_n),
		.int_rst   (int_rst_w),
		.standby   (standby_w)
	);

	//--------------------------------------------------------------
	// clock and phy control
	//--------------------------------------------------------------
	logic next_phy_en;
	logic next_osc_en;

	always_comb begin
		// crystal and pll halt for the whole external reset
		next_osc_en = ext_rst_n && !rst; // [R7]
		// phy off floats the pairs
		next_phy_en = !int_rst_w; // [R4]
	end

	always_ff @(posedge mclk) begin
		int_rst    <= int_rst_w;
		standby    <= standby_w; // [R3]
		phy_en     <= next_phy_en;
		pair_oe    <= next_phy_en; // [R4]
		osc_en     <= next_osc_en;
		pll_en     <= next_osc_en; // [R7]
		ds_reset   <= 1'b0; // [R11]
	end

	//--------------------------------------------------------------
	// device state
	//--------------------------------------------------------------
	logic [6:0] next_dev_addr;
	logic [7:0] next_dev_config;
	logic       next_xact_busy;

	always_comb begin
		next_dev_addr   = dev_addr;
		next_dev_config = dev_config;
		next_xact_busy  = xact_busy;
		if (int_rst_w) begin // [R5] [R6]
			next_dev_addr   = ADDR_RESET;
			next_dev_config = CONFIG_RESET;
			next_xact_busy  = 1'b0;
		end else if (bus_reset) begin
			next_dev_addr   = ADDR_RESET; // [R8]
			next_dev_config = CONFIG_RESET; // [R9]
			next_xact_busy  = 1'b0;
		end else begin
			if (set_addr) begin
				next_dev_addr = addr_in;
			end
			if (set_config) begin
				next_dev_config = config_in;
			end
			next_xact_busy = xact_req && (link_state == 2'h0);
		end
	end

	always_ff @(posedge mclk) begin
		dev_addr   <= next_dev_addr;
		dev_config <= next_dev_config;
		xact_busy  <= next_xact_busy;
	end

	//--------------------------------------------------------------
	// link power states
	//--------------------------------------------------------------
	// l2 counts exceed 4096 cycles, so they are top parameters
	hrlp_link_type    lstate;
	hrlp_link_type    next_lstate;
	logic [CNT_W-1:0] lcnt;
	logic [CNT_W-1:0] next_lcnt;
	logic [1:0]       next_link_state;
	logic             next_link_busy;

	always_comb begin
		next_lstate = lstate;
		next_lcnt   = (lcnt != '0) ? lcnt - CNT_W'(1) : lcnt;
		if (int_rst_w) begin
			next_lstate = HRLP_L0;
			next_lcnt   = '0;
		end else if (bus_reset) begin
			// bus reset wakes a suspended link at once
			next_lstate = HRLP_L0; // [R10]
			next_lcnt   = '0;
		end else begin
			case (lstate) // [R12]
			HRLP_L0: begin
				if (l2_req) begin
					next_lstate = HRLP_L2_ENTER;
					next_lcnt   = CNT_W'(L2_ENTER_CYC); // [R13]
				end else if (l1_req) begin
					next_lstate = HRLP_L1_ENTER;
					next_lcnt   = CNT_W'(L1_ENTER_CYC); // [R14]
				end
			end
			HRLP_L1_ENTER: begin
				if (lcnt == '0) begin
					next_lstate = HRLP_L1;
				end
			end
			HRLP_L1: begin
				if (resume) begin
					next_lstate = HRLP_L1_EXIT;
					next_lcnt   = CNT_W'(L1_LEAVE_CYC); // [R14]
				end
			end
			HRLP_L1_EXIT: begin
				if (lcnt == '0) begin
					next_lstate = HRLP_L0;
				end
			end
			HRLP_L2_ENTER: begin
				if (lcnt == '0) begin
					next_lstate = HRLP_L2;
				end
			end
			HRLP_L2: begin
				if (resume) begin
					next_lstate = HRLP_L2_EXIT;
					next_lcnt   = CNT_W'(L2_LEAVE_CYC); // [R13]
				end
			end
			HRLP_L2_EXIT: begin
				if (lcnt == '0) begin
					next_lstate = HRLP_L0;
				end
			end
			default: begin
				next_lstate = HRLP_L0;
			end
			endcase
		end
		case (next_lstate)
		HRLP_L1:  next_link_state = 2'h1;
		HRLP_L2:  next_link_state = 2'h2;
		default:  next_link_state = 2'h0;
		endcase
		// a state is reported once reached; exits keep the old state
		if (next_lstate == HRLP_L1_EXIT) begin
			next_link_state = 2'h1;
		end
		if (next_lstate == HRLP_L2_EXIT) begin
			next_link_state = 2'h2;
		end
		next_link_busy = (next_lstate == HRLP_L1_ENTER) ||
			(next_lstate == HRLP_L1_EXIT) ||
			(next_lstate == HRLP_L2_ENTER) ||
			(next_lstate == HRLP_L2_EXIT);
	end

	always_ff @(posedge mclk) begin
		lstate     <= next_lstate;
		lcnt       <= next_lcnt;
		link_state <= next_link_state;
		link_busy  <= next_link_busy;
	end

	//--------------------------------------------------------------
	// checks
	//--------------------------------------------------------------
	property p_bus_addr;
		@(posedge mclk) disable iff (rst) bus_reset |=> dev_addr == 7'h00;
	endproperty
	a_bus_addr: assert property (p_bus_addr) // [R8]
		else $error("address not cleared by bus reset");

	property p_bus_cfg;
		@(posedge mclk) disable iff (rst) bus_reset |=> dev_config == 8'h00;
	endproperty
	a_bus_cfg: assert property (p_bus_cfg) // [R9]
		else $error("configuration not cleared by bus reset");

	property p_bus_wake;
		@(posedge mclk) disable iff (rst)
			bus_reset && !int_rst_w |=> link_state == 2'h0 && !link_busy;
	endproperty
	a_bus_wake: assert property (p_bus_wake) // [R10]
		else $error("bus reset did not wake link");

	property p_no_fwd;
		@(posedge mclk) disable iff (rst) bus_reset |=> ##1 !ds_reset;
	endproperty
	a_no_fwd: assert property (p_no_fwd) // [R11]
		else $error("bus reset forwarded downstream");

	property p_ext_phy;
		@(posedge mclk) disable iff (rst) !ext_rst_n |=> ##1 !phy_en && !pair_oe;
	endproperty
	a_ext_phy: assert property (p_ext_phy) // [R4]
		else $error("phy still driving under external reset");

	property p_ext_osc;
		@(posedge mclk) disable iff (rst) !ext_rst_n |=> !osc_en && !pll_en;
	endproperty
	a_ext_osc: assert property (p_ext_osc) // [R7]
		else $error("oscillator running under external reset");

	property p_ext_clear;
		@(posedge mclk) disable iff (rst)
			!ext_rst_n |=> ##1 !xact_busy && dev_addr == 7'h00;
	endproperty
	a_ext_clear: assert property (p_ext_clear) // [R5]
		else $error("state kept across external reset");

	property p_l1_exit;
		@(posedge mclk) disable iff (rst || int_rst_w || bus_reset)
			lstate == HRLP_L1 && resume |=> lstate == HRLP_L1_EXIT;
	endproperty
	a_l1_exit: assert property (p_l1_exit) // [R14]
		else $error("l1 exit not started on resume");

	property p_ext_standby;
		@(posedge mclk) disable iff (rst) !ext_rst_n |=> ##1 standby;
	endproperty
	a_ext_standby: assert property (p_ext_standby) // [R3]
		else $error("standby not shown under external reset");

	property p_l2_enter;
		@(posedge mclk) disable iff (rst)
			!int_rst_w && !bus_reset && lstate == HRLP_L0 && l2_req
			|=> lstate == HRLP_L2_ENTER && lcnt == CNT_W'(L2_ENTER_CYC);
	endproperty
	a_l2_enter: assert property (p_l2_enter) // [R13]
		else $error("l2 entry not started with its count");

	property p_l1_enter;
		@(posedge mclk) disable iff (rst)
			!int_rst_w && !bus_reset && lstate == HRLP_L0 &&
			l1_req && !l2_req |=>
			lstate == HRLP_L1_ENTER && lcnt == CNT_W'(L1_ENTER_CYC);
	endproperty
	a_l1_enter: assert property (p_l1_enter) // [R14]
		else $error("l1 entry not started with its count");

	property p_l2_exit;
		@(posedge mclk) disable iff (rst)
			!int_rst_w && !bus_reset && lstate == HRLP_L2 && resume
			|=> lstate == HRLP_L2_EXIT && lcnt == CNT_W'(L2_LEAVE_CYC);
	endproperty
	a_l2_exit: assert property (p_l2_exit) // [R13]
		else $error("l2 exit not started on resume");

	property p_l1_bound;
		@(posedge mclk) disable iff (rst)
			lstate == HRLP_L1_ENTER |-> lcnt <= CNT_W'(L1_ENTER_CYC);
	endproperty
	a_l1_bound: assert property (p_l1_bound) // [R14]
		else $error("l1 entry count beyond its limit");

	property p_l1_shown;
		@(posedge mclk) disable iff (rst)
			lstate == HRLP_L1 |-> link_state == 2'h1 && !link_busy;
	endproperty
	a_l1_shown: assert property (p_l1_shown) // [R12]
		else $error("sleep state not reported");

	property p_l2_shown;
		@(posedge mclk) disable iff (rst)
			lstate == HRLP_L2 |-> link_state == 2'h2 && !link_busy;
	endproperty
	a_l2_shown: assert property (p_l2_shown) // [R12]
		else $error("suspend state not reported");

	property p_ext_regs;
		@(posedge mclk) disable iff (rst)
			!ext_rst_n |=> ##1 dev_config == CONFIG_RESET &&
			lstate == HRLP_L0 && link_state == 2'h0 && !link_busy;
	endproperty
	a_ext_regs: assert property (p_ext_regs) // [R6]
		else $error("registers not at default under external reset");
endmodule
`default_nettype wire

//--- dv/hrlp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module hrlp_host_model (
	input  wire logic supply_ok, // supplies in range
	input  wire logic pin_req,   // ask for a pin reset
	input  wire logic bus_req,   // ask for an upstream bus reset
	output logic      ext_rst_n, // reset pin, low active
	output logic      bus_reset  // upstream bus reset level
);
	// the pin is only pulled while supplies are good, whatever is asked;
	// following the requests at once avoids racing the bench's edge
	always_comb begin
		ext_rst_n = !(pin_req && supply_ok);
		bus_reset = bus_req;
	end
endmodule
`default_nettype wire

//--- dv/tb_hrlp_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_hrlp_top;
	import hrlp_pkg::*;
	localparam int POR = 16;
	localparam int L2E = 20;
	localparam int L2X = 20;
	localparam int L1E = 8;
	localparam int L1X = 12;
	logic       mclk, rst, sup, pin_req, bus_req, ext_rst_n, bus_reset;
	logic       set_addr, set_config, l1_req, l2_req, resume, xact_req;
	logic [6:0] addr_in, dev_addr;
	logic [7:0] config_in, dev_config;
	logic       int_rst, standby, phy_en, pair_oe, osc_en, pll_en;
	logic       xact_busy, link_busy, ds_reset;
	logic [1:0] link_state;
	int         n_errors, samples_checked, cyc, n;

	hrlp_host_model host (.supply_ok(sup), .pin_req(pin_req),
		.bus_req(bus_req), .ext_rst_n(ext_rst_n), .bus_reset(bus_reset));

	hrlp_top #(.POR_CYC(POR), .L2_ENTER_CYC(L2E), .L2_LEAVE_CYC(L2X),
		.L1_ENTER_CYC(L1E), .L1_LEAVE_CYC(L1X)) dut (.mclk(mclk),
		.rst(rst), .ext_rst_n(ext_rst_n), .bus_reset(bus_reset),
		.set_addr(set_addr), .addr_in(addr_in), .set_config(set_config),
		.config_in(config_in), .l1_req(l1_req), .l2_req(l2_req),
		.resume(resume), .xact_req(xact_req), .int_rst(int_rst),
		.standby(standby), .phy_en(phy_en), .pair_oe(pair_oe),
		.osc_en(osc_en), .pll_en(pll_en), .dev_addr(dev_addr),
		.dev_config(dev_config), .xact_busy(xact_busy),
		.link_state(link_state), .link_busy(link_busy),
		.ds_reset(ds_reset));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic wait_rst(output int cnt);
		cnt = 0;
		while (int_rst !== 1'b0 && cnt < 300) begin
			@(negedge mclk);
			cnt++;
		end
	endtask

	task automatic wait_state(input logic [1:0] v, output int cnt);
		cnt = 0;
		while ((link_state !== v || link_busy !== 1'b0) && cnt < 300) begin
			@(negedge mclk);
			cnt++;
		end
	endtask

	// one cycle strobe: 0 sleep, 1 suspend, 2 resume, 3 address assign
	task automatic pulse(input logic [1:0] sel);
		{set_addr, resume, l2_req, l1_req} = 4'h1 << sel;
		@(negedge mclk);
		{set_addr, resume, l2_req, l1_req} = 4'h0;
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_por();
		chk(int_rst, 1'b1);
		wait_rst(n);
		chk(n >= POR && n <= POR + 4, 1'b1);
		chk({osc_en, pll_en, phy_en, pair_oe, standby, ds_reset},
			8'h3c);
		chk(link_state, 8'h00);
		$display("test por done");
	endtask

	task automatic t_lpm();
		pulse(2'h0);
		chk(link_busy, 1'b1);
		wait_state(2'h1, n);
		chk(n >= L1E && n <= L1E + 4, 1'b1);
		// suspend and transactions are only taken in l0
		xact_req = 1'b1;
		pulse(2'h1);
		chk({link_state, link_busy, xact_busy}, 8'h04);
		xact_req = 1'b0;
		pulse(2'h2);
		wait_state(2'h0, n);
		chk(n >= L1X && n <= L1X + 4, 1'b1);
		pulse(2'h1);
		wait_state(2'h2, n);
		chk(n >= L2E && n <= L2E + 4, 1'b1);
		pulse(2'h2);
		wait_state(2'h0, n);
		chk(n >= L2X && n <= L2X + 4, 1'b1);
		$display("test lpm done");
	endtask

	task automatic t_bus();
		addr_in = 7'h7f;
		config_in = 8'h01;
		set_addr = 1'b1;
		set_config = 1'b1;
		@(negedge mclk);
		set_addr = 1'b0;
		set_config = 1'b0;
		@(negedge mclk);
		chk(dev_addr, 8'h7f);
		chk(dev_config, 8'h01);
		pulse(2'h1);
		wait_state(2'h2, n);
		chk(link_state, 8'h02);
		bus_req = 1'b1;
		repeat (4) @(negedge mclk);
		chk(ds_reset, 1'b0);
		bus_req = 1'b0;
		wait_state(2'h0, n);
		chk(dev_addr, 8'h00);
		chk(dev_config, 8'h00);
		chk(link_state, 8'h00);
		$display("test bus reset done");
	endtask

	task automatic t_ext();
		addr_in = 7'h2a;
		pulse(2'h3);
		xact_req = 1'b1;
		repeat (2) @(negedge mclk);
		chk(xact_busy, 1'b1);
		pin_req = 1'b1;
		repeat (4) @(negedge mclk);
		chk({standby, phy_en, pair_oe}, 8'h04);
		chk({osc_en, pll_en}, 8'h00);
		chk(xact_busy, 1'b0);
		chk(dev_addr, 8'h00);
		pin_req = 1'b0;
		xact_req = 1'b0;
		@(negedge mclk);
		chk(int_rst, 1'b1);
		wait_rst(n);
		chk(n >= POR && n <= POR + 4, 1'b1);
		$display("test pin reset done");
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 4000) begin
			n_errors++;
			report_and_stop();
		end
	end

	initial begin
		{rst, sup} = 2'b10;
		{pin_req, bus_req, set_addr, set_config} = 4'h0;
		{l1_req, l2_req, resume, xact_req} = 4'h0;
		addr_in = 7'h00;
		config_in = 8'h00;
		n_errors = 0;
		samples_checked = 0;
		cyc = 0;
		repeat (8) @(negedge mclk);
		rst = 1'b0;
		sup = 1'b1;
		@(negedge mclk);
		t_por();
		t_lpm();
		t_bus();
		t_ext();
		report_and_stop();
	end
endmodule
`default_nettype wire
